// file: design/ptb_pkg.sv
// Functional notes
// - length select: 16 bytes high, 64 low
// - short mode: byte with msb set goes first
// - long mode: byte after CR LF goes first
// - alignment disabled: plain circular capture buffer
// - zero message high: send zeros, else buffer
// - accept after five or three identical messages
// - unstable after eight consecutive differing messages
// - unstable clears when current message is accepted
// - mismatch state follows accepted versus expected
// - mismatch event on change, cleared by read
// - unstable event on change, cleared by read
// - mismatch event drives irq when enabled
// - unstable event drives irq when enabled
// - buffer select: receive pages high, transmit low
// - receive: 0-63 capture, 64-127 expected
// - address write starts access, direction bit read
// - data register holds write byte or read result
// - busy rises on address write until done
package ptb_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] PTB_IDX_CTRL = 8'h68;
    localparam logic [7:0] PTB_IDX_STAT = 8'h69;
    localparam logic [7:0] PTB_IDX_IADDR = 8'h6A;
    localparam logic [7:0] PTB_IDX_IDATA = 8'h6B;

    // reset values
    localparam logic [7:0] PTB_CTRL_RESET = 8'h04;
    localparam logic [7:0] PTB_BYTE_ZERO = 8'h00;

    // indirect address fields
    localparam int PTB_DIR_BIT = 7;
    localparam int PTB_PAGE_BIT = 6;

    // message framing bytes
    localparam logic [7:0] PTB_CR = 8'h0D;
    localparam logic [7:0] PTB_LF = 8'h0A;

    // last byte position and byte count of each message length
    localparam logic [5:0] PTB_LAST_SHORT = 6'h0F;
    localparam logic [5:0] PTB_LAST_LONG = 6'h3F;
    localparam int PTB_LEN_SHORT = 16;
    localparam int PTB_LEN_LONG = 64;

    // persistence, instability and access cycle counts
    localparam logic [2:0] PTB_PERSIST_HI = 3'h5;
    localparam logic [2:0] PTB_PERSIST_LO = 3'h3;
    localparam int PTB_UNSTABLE_MSGS = 8;
    localparam int PTB_ACCESS_CYCLES = 2;

    // control register layout
    typedef struct packed {
        logic rsvd;
        logic rx_sel;
        logic uns_ie;
        logic mis_ie;
        logic persistence_select;
        logic tx_zero;
        logic align_dis;
        logic short_message_select;
    } ptb_ctrl_t;

    // status register layout
    typedef struct packed {
        logic busy;
        logic [2:0] rsvd;
        logic uns_ev;
        logic uns_v;
        logic mis_ev;
        logic mis_v;
    } ptb_stat_t;

    // one whole message page
    typedef logic [63:0][7:0] ptb_msg_t;

    // complete state of the trace buffer
    typedef struct packed {
        ptb_ctrl_t ctrl;
        logic [7:0] iaddr;
        logic [7:0] idata;
        logic mis_v;
        logic mis_ev;
        logic uns_v;
        logic uns_ev;
        ptb_msg_t cap;
        ptb_msg_t expct;
        ptb_msg_t txb;
        ptb_msg_t acc;
        logic [5:0] rx_ptr;
        logic [5:0] tx_ptr;
        logic [7:0] last_byte;
        logic crlf;
        logic diff_acc;
        logic [2:0] same_cnt;
        logic [3:0] diff_cnt;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] tx_data;
    } ptb_state_t;

    // busy timer state
    typedef struct packed {
        logic busy;
        logic [3:0] cnt;
    } ptb_timer_t;

endpackage : ptb_pkg

// file: design/ptb_busy_timer.sv
`timescale 1ns/1ps
// indirect access timer: busy from start until done
module ptb_busy_timer import ptb_pkg::*; #(
    parameter int CYCLES = PTB_ACCESS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);

    ptb_timer_t s_q; // registered state
    ptb_timer_t s_d; // next state

    // done in the last busy cycle
    assign done_o = s_q.busy && (s_q.cnt == 4'(CYCLES - 1));
    assign busy_o = s_q.busy;

    // next state
    always_comb begin
        s_d = s_q;
        if (start_i) begin
            s_d.busy = 1'b1;
            s_d.cnt = 4'h0;
        end else if (done_o) begin // access finished
            s_d.busy = 1'b0;
        end else if (s_q.busy) begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_busy_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        start_i |=> busy_o ##(CYCLES - 1) (done_o && busy_o) ##1 !busy_o)
        else $error("busy did not end after the access time");

endmodule : ptb_busy_timer

// file: design/ptb_trace_buffer.sv
`timescale 1ns/1ps
// path trace buffer with avalon-mm register slave
module ptb_trace_buffer import ptb_pkg::*; #(
    parameter int UNSTABLE_MSGS = PTB_UNSTABLE_MSGS,
    parameter int ACCESS_CYCLES = PTB_ACCESS_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    input wire logic [9:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic RX_J1_VALID_I,
    input wire logic [7:0] RX_J1_DATA_I,
    input wire logic TX_J1_REQ_I,
    output logic [7:0] TX_J1_DATA_O,
    output logic IRQ_OUT_N_O
);

    ptb_state_t s_q; // registered state
    ptb_state_t s_d; // next state

    logic busy; // indirect access in flight
    logic done; // last cycle of indirect access
    logic start; // address write accepted
    logic acc_wr; // bus write takes effect
    logic acc_rd; // bus read completes
    logic msg_end; // last byte of a message received
    logic msg_same; // finished message equals previous
    logic accept_now; // message becomes the accepted one
    logic [2:0] need; // identical messages needed

    // register hit at the word of a given index
    function automatic logic reg_hit(input logic [9:0] a, input logic [7:0] idx);
        return (a[9:2] == idx) && (a[1:0] == 2'b00);
    endfunction : reg_hit

    // last position of the selected message length
    function automatic logic [5:0] last_pos(input logic short_message_select);
        return short_message_select ? PTB_LAST_SHORT : PTB_LAST_LONG;
    endfunction : last_pos

    // next position with wrap at the message length
    function automatic logic [5:0] next_pos(input logic [5:0] p, input logic short_message_select);
        return (p >= last_pos(short_message_select)) ? 6'h00 : 6'(p + 6'h01);
    endfunction : next_pos

    // compare two pages over the message length
    function automatic logic msg_equal(input ptb_msg_t a, input ptb_msg_t b,
                                       input logic short_message_select);
        logic eq;
        int len;
        eq = 1'b1;
        len = short_message_select ? PTB_LEN_SHORT : PTB_LEN_LONG;
        for (int i = 0; i < PTB_LEN_LONG; i++) begin
            if ((i < len) && (a[i] != b[i])) begin
                eq = 1'b0;
            end
        end
        return eq;
    endfunction : msg_equal

    // indirect access timer
    ptb_busy_timer #(
        .CYCLES(ACCESS_CYCLES)
    ) u_timer (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .start_i(start),
        .busy_o(busy),
        .done_o(done)
    );

    // bus handshake: one wait cycle per transfer
    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !s_q.ack;
    assign acc_wr = AVS_WRITE_I && s_q.ack && AVS_BYTEENABLE_I[0];
    assign acc_rd = AVS_READ_I && s_q.ack;
    assign AVS_READDATA_O = s_q.rdata;
    assign TX_J1_DATA_O = s_q.tx_data;
    // address write while busy is ignored
    assign start = acc_wr && reg_hit(AVS_ADDRESS_I, PTB_IDX_IADDR) && !busy;
    assign need = s_q.ctrl.persistence_select ? PTB_PERSIST_HI : PTB_PERSIST_LO;

    // shared interrupt, active low
    assign IRQ_OUT_N_O = !((s_q.mis_ev && s_q.ctrl.mis_ie)
                        || (s_q.uns_ev && s_q.ctrl.uns_ie));

    // next-state logic
    always_comb begin
        ptb_stat_t st;
        ptb_stat_t rep;
        logic [5:0] pos;
        logic align;
        logic dacc;
        logic [7:0] sel;
        s_d = s_q;
        st = '0;
        rep = '0;
        pos = s_q.rx_ptr;
        align = 1'b0;
        dacc = 1'b0;
        sel = PTB_BYTE_ZERO;
        msg_end = 1'b0;
        msg_same = 1'b0;
        accept_now = 1'b0;

        // status image
        st.busy = busy;
        st.uns_ev = s_q.uns_ev;
        st.uns_v = s_q.uns_v;
        st.mis_ev = s_q.mis_ev;
        st.mis_v = s_q.mis_v;

        // byte addressed by the indirect address
        if (s_q.ctrl.rx_sel) begin
            if (s_q.iaddr[PTB_PAGE_BIT]) begin
                sel = s_q.expct[s_q.iaddr[5:0]];
            end else begin
                sel = s_q.cap[s_q.iaddr[5:0]];
            end
        end else begin // transmit page, upper half aliases
            sel = s_q.txb[s_q.iaddr[5:0]];
        end

        // first bus cycle: capture read data
        s_d.ack = (AVS_READ_I || AVS_WRITE_I) && !s_q.ack;
        if (AVS_READ_I && !s_q.ack) begin
            if (reg_hit(AVS_ADDRESS_I, PTB_IDX_CTRL)) begin
                s_d.rdata = {24'h000000, s_q.ctrl};
            end else if (reg_hit(AVS_ADDRESS_I, PTB_IDX_STAT)) begin
                s_d.rdata = {24'h000000, st};
            end else if (reg_hit(AVS_ADDRESS_I, PTB_IDX_IADDR)) begin
                s_d.rdata = {24'h000000, s_q.iaddr};
            end else if (reg_hit(AVS_ADDRESS_I, PTB_IDX_IDATA)) begin
                s_d.rdata = {24'h000000, s_q.idata};
            end else begin // unmapped reads zero
                s_d.rdata = 32'h00000000;
            end
        end

        // receive stream capture
        if (RX_J1_VALID_I) begin
            if (!s_q.ctrl.align_dis) begin
                align = s_q.ctrl.short_message_select ? RX_J1_DATA_I[7]
                                       : s_q.crlf;
            end
            if (align) begin
                pos = 6'h00;
            end
            // capture still holds the previous message here
            dacc = ((pos == 6'h00) ? 1'b0 : s_q.diff_acc)
                 || (RX_J1_DATA_I != s_q.cap[pos]);
            s_d.cap[pos] = RX_J1_DATA_I;
            s_d.crlf = (s_q.last_byte == PTB_CR) && (RX_J1_DATA_I == PTB_LF);
            s_d.last_byte = RX_J1_DATA_I;
            s_d.rx_ptr = next_pos(pos, s_q.ctrl.short_message_select);
            s_d.diff_acc = dacc;
            if (pos >= last_pos(s_q.ctrl.short_message_select)) begin // message complete
                msg_end = 1'b1;
                msg_same = !dacc;
                s_d.diff_acc = 1'b0;
            end
        end

        // persistence and instability
        if (msg_end && msg_same) begin
            s_d.diff_cnt = 4'h0;
            if (s_q.same_cnt < need) begin
                s_d.same_cnt = s_q.same_cnt + 3'h1;
                if ((s_q.same_cnt + 3'h1) == need) begin
                    accept_now = 1'b1;
                end
            end
        end else if (msg_end) begin
            s_d.same_cnt = 3'h1;
            if (s_q.diff_cnt < 4'(UNSTABLE_MSGS)) begin
                s_d.diff_cnt = s_q.diff_cnt + 4'h1;
            end
            if ((s_q.diff_cnt + 4'h1) >= 4'(UNSTABLE_MSGS)) begin
                s_d.uns_v = 1'b1;
            end
        end
        if (accept_now) begin
            s_d.acc = s_d.cap;
            s_d.uns_v = 1'b0;
        end

        // mismatch follows accepted versus expected
        s_d.mis_v = !msg_equal(s_q.acc, s_q.expct, s_q.ctrl.short_message_select);

        // transmit byte supply
        if (TX_J1_REQ_I) begin
            s_d.tx_data = s_q.ctrl.tx_zero ? PTB_BYTE_ZERO
                                           : s_q.txb[s_q.tx_ptr];
            s_d.tx_ptr = next_pos(s_q.tx_ptr, s_q.ctrl.short_message_select);
        end

        // register writes
        if (acc_wr) begin
            if (reg_hit(AVS_ADDRESS_I, PTB_IDX_CTRL)) begin
                s_d.ctrl = ptb_ctrl_t'(AVS_WRITEDATA_I[7:0]);
                s_d.ctrl.rsvd = 1'b0;
            end else if (start) begin
                s_d.iaddr = AVS_WRITEDATA_I[7:0];
            end else if (reg_hit(AVS_ADDRESS_I, PTB_IDX_IDATA)) begin
                s_d.idata = AVS_WRITEDATA_I[7:0];
            end
        end

        // indirect access completes
        if (done) begin
            if (s_q.iaddr[PTB_DIR_BIT]) begin
                s_d.idata = sel;
            end else if (!s_q.ctrl.rx_sel) begin
                s_d.txb[s_q.iaddr[5:0]] = s_q.idata;
            end else if (s_q.iaddr[PTB_PAGE_BIT]) begin
                s_d.expct[s_q.iaddr[5:0]] = s_q.idata;
            end else begin
                s_d.cap[s_q.iaddr[5:0]] = s_q.idata;
            end
        end

        // events: clear only what the read reported, set wins
        if (acc_rd && reg_hit(AVS_ADDRESS_I, PTB_IDX_STAT)) begin
            rep = ptb_stat_t'(s_q.rdata[7:0]);
            s_d.mis_ev = s_q.mis_ev && !rep.mis_ev;
            s_d.uns_ev = s_q.uns_ev && !rep.uns_ev;
        end
        if (s_d.mis_v != s_q.mis_v) begin
            s_d.mis_ev = 1'b1;
        end
        if (s_d.uns_v != s_q.uns_v) begin
            s_d.uns_ev = 1'b1;
        end
    end

    // state register
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_q <= '0;
            s_q.ctrl <= ptb_ctrl_t'(PTB_CTRL_RESET);
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    // address register write on the bus
    sequence s_addr_write;
        acc_wr && reg_hit(AVS_ADDRESS_I, PTB_IDX_IADDR) && !busy;
    endsequence

    // a byte with the msb set in short aligned mode
    sequence s_msb_byte;
        RX_J1_VALID_I && s_q.ctrl.short_message_select && !s_q.ctrl.align_dis && RX_J1_DATA_I[7];
    endsequence

    a_short_wrap: assert property (
        RX_J1_VALID_I && s_q.ctrl.short_message_select && !s_q.ctrl.align_dis
        && !RX_J1_DATA_I[7] && s_q.rx_ptr == PTB_LAST_SHORT |=> s_q.rx_ptr == 6'h00)
        else $error("short message pointer did not wrap");
    a_msb_align: assert property (
        s_msb_byte |=> s_q.rx_ptr == 6'h01 && s_q.cap[0] == $past(RX_J1_DATA_I))
        else $error("msb byte not stored first");
    a_crlf_align: assert property (
        RX_J1_VALID_I && !s_q.ctrl.short_message_select && !s_q.ctrl.align_dis && s_q.crlf
        |=> s_q.rx_ptr == 6'h01)
        else $error("byte after cr lf not stored first");
    a_circular_fill: assert property (
        RX_J1_VALID_I && s_q.ctrl.align_dis && s_q.rx_ptr < PTB_LAST_SHORT
        |=> s_q.rx_ptr == 6'($past(s_q.rx_ptr) + 6'h01))
        else $error("circular buffer skipped a position");
    a_tx_zero: assert property (
        TX_J1_REQ_I && s_q.ctrl.tx_zero |=> TX_J1_DATA_O == PTB_BYTE_ZERO)
        else $error("zero message not sent");
    a_accept_count: assert property (
        accept_now |-> s_q.same_cnt == 3'(need - 3'h1) && msg_same)
        else $error("message accepted at the wrong count");
    a_unstable_set: assert property (
        $rose(s_q.uns_v) |-> $past(s_q.diff_cnt) >= 4'(UNSTABLE_MSGS - 1))
        else $error("unstable set too early");
    a_unstable_clear: assert property (
        accept_now |=> !s_q.uns_v && s_q.acc == s_q.cap)
        else $error("unstable not cleared on acceptance");
    a_mismatch_track: assert property (
        $stable(s_q.acc) && $stable(s_q.expct) && $stable(s_q.ctrl)
        |-> s_q.mis_v == !msg_equal(s_q.acc, s_q.expct, s_q.ctrl.short_message_select))
        else $error("mismatch state does not follow compare");
    a_mis_event: assert property (
        $changed(s_q.mis_v) |-> s_q.mis_ev)
        else $error("mismatch event not set on change");
    a_uns_event: assert property (
        $changed(s_q.uns_v) |-> s_q.uns_ev)
        else $error("unstable event not set on change");
    a_irq_gate: assert property (
        !IRQ_OUT_N_O |-> (s_q.mis_ev && s_q.ctrl.mis_ie) || (s_q.uns_ev && s_q.ctrl.uns_ie))
        else $error("interrupt without enabled event");
    a_irq_raise: assert property (
        s_q.uns_ev && s_q.ctrl.uns_ie |-> !IRQ_OUT_N_O)
        else $error("enabled unstable event missing on irq");
    a_busy_rise: assert property (
        s_addr_write |=> busy && s_q.iaddr == $past(AVS_WRITEDATA_I[7:0]))
        else $error("busy not raised on address write");
    a_restart_count: assert property (
        msg_end && !msg_same |=> s_q.same_cnt == 3'h1)
        else $error("persistence count not restarted");

    // status read drops a reported mismatch event unless a new change lands
    a_mis_clear: assert property (
        acc_rd && reg_hit(AVS_ADDRESS_I, PTB_IDX_STAT) && s_q.rdata[1]
        |=> !s_q.mis_ev || $changed(s_q.mis_v))
        else $error("mismatch event survived its status read");
    // same for the unstable event
    a_uns_clear: assert property (
        acc_rd && reg_hit(AVS_ADDRESS_I, PTB_IDX_STAT) && s_q.rdata[3]
        |=> !s_q.uns_ev || $changed(s_q.uns_v))
        else $error("unstable event survived its status read");
    // enabled mismatch event pulls the shared line
    a_mis_irq: assert property (
        s_q.mis_ev && s_q.ctrl.mis_ie |-> !IRQ_OUT_N_O)
        else $error("enabled mismatch event missing on irq");
    // buffer byte goes out when zero message is off
    a_tx_supply: assert property (
        TX_J1_REQ_I && !s_q.ctrl.tx_zero |=> TX_J1_DATA_O == $past(s_q.txb[s_q.tx_ptr]))
        else $error("transmit byte not taken from the buffer");
    // transmit side selected: indirect write lands in the transmit page
    a_tx_write: assert property (
        done && !s_q.iaddr[PTB_DIR_BIT] && !s_q.ctrl.rx_sel
        |=> s_q.txb[$past(s_q.iaddr[5:0])] == $past(s_q.idata))
        else $error("indirect write missed the transmit page");
    // upper receive addresses hold the expected page
    a_exp_write: assert property (
        done && !s_q.iaddr[PTB_DIR_BIT] && s_q.ctrl.rx_sel && s_q.iaddr[PTB_PAGE_BIT]
        |=> s_q.expct[$past(s_q.iaddr[5:0])] == $past(s_q.idata))
        else $error("indirect write missed the expected page");
    // indirect read leaves the addressed transmit byte in the data register
    a_dir_read: assert property (
        done && s_q.iaddr[PTB_DIR_BIT] && !s_q.ctrl.rx_sel
        |=> s_q.idata == s_q.txb[$past(s_q.iaddr[5:0])])
        else $error("indirect read data not placed in the data register");

endmodule : ptb_trace_buffer

// file: test/ptb_poh_model.sv
`timescale 1ns/1ps
// overhead processor stand-in: feeds rx j1 bytes, pulls tx j1 bytes
module ptb_poh_model import ptb_pkg::*; (
    input wire logic clk_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic tx_req_o,
    input wire logic [7:0] tx_data_i
);
    logic [7:0] last_q; // last byte put on the line

    // quiet line at time zero
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        tx_req_o = 1'b0;
        last_q = 8'h00;
    end

    // one byte per cycle when called back to back
    task automatic put_byte(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        last_q = b;
    endtask : put_byte

    // released line shows the inverse of the last byte, never a stale copy
    task automatic idle();
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~last_q;
    endtask : idle

    // whole message of len bytes, then release
    task automatic put_msg(input ptb_msg_t m, input int len);
        for (int j = 0; j < len; j++) begin
            put_byte(m[j]);
        end
        idle();
    endtask : put_msg

    // one-cycle request; byte is settled the cycle after it
    task automatic get_byte(output logic [7:0] b);
        @(posedge clk_i);
        tx_req_o <= 1'b1;
        @(posedge clk_i);
        tx_req_o <= 1'b0;
        @(negedge clk_i);
        b = tx_data_i;
    endtask : get_byte
endmodule : ptb_poh_model

// file: test/ptb_trace_buffer_tb.sv
`timescale 1ns/1ps
// register-level bench for the trace buffer
module ptb_trace_buffer_tb import ptb_pkg::*;;
    localparam int LIMIT = 20000; // watchdog ceiling in cycles
    logic ref_clk; // 50 mhz system clock
    logic rst_n; // async reset, active low
    logic [9:0] addr; // avalon byte address
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic waitreq;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_req;
    logic [7:0] tx_data;
    logic irq_n;
    logic [3:0] be; // avalon byte lanes
    int n_mismatch; // mismatches seen
    int tests_run; // comparisons made
    int cycles; // watchdog count
    logic [7:0] q8;
    ptb_msg_t m_a;
    ptb_msg_t m_b;
    ptb_msg_t m_c;

    ptb_trace_buffer #(.UNSTABLE_MSGS(8), .ACCESS_CYCLES(4)) i_ptb_trace_buffer (
        .REF_CLK_I(ref_clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be),
        .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .RX_J1_VALID_I(rx_valid), .RX_J1_DATA_I(rx_data), .TX_J1_REQ_I(tx_req),
        .TX_J1_DATA_O(tx_data), .IRQ_OUT_N_O(irq_n)
    );

    ptb_poh_model i_ptb_poh_model (
        .clk_i(ref_clk), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .tx_req_o(tx_req), .tx_data_i(tx_data)
    );

    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // report counts and verdict, then stop
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // single comparison point
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge ref_clk);
        addr <= {idx, 2'b00};
        wr <= we;
        rd <= ~we;
        wdata <= {24'h000000, d};
        @(posedge ref_clk);
        while (waitreq !== 1'b0) @(posedge ref_clk);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, exp);
    endtask : rd_chk

    // busy must show at once, then wait until it drops
    task automatic poll();
        logic [7:0] q;
        bus(1'b0, PTB_IDX_STAT, 8'h00, q);
        chk({7'h00, q[7]}, 8'h01);
        while (q[7] !== 1'b0) bus(1'b0, PTB_IDX_STAT, 8'h00, q);
    endtask : poll

    task automatic ind_write(input logic [6:0] a, input logic [7:0] d);
        wr_reg(PTB_IDX_IDATA, d);
        wr_reg(PTB_IDX_IADDR, {1'b0, a});
        poll();
    endtask : ind_write

    task automatic ind_chk(input logic [6:0] a, input logic [7:0] exp);
        wr_reg(PTB_IDX_IADDR, {1'b1, a});
        poll();
        rd_chk(PTB_IDX_IDATA, exp);
    endtask : ind_chk

    // interrupt line, looked at once a state change has reached the event flags
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h00, irq_n}, {7'h00, exp});
    endtask : irq_chk

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // short message: sync byte first, the rest below 0x80
    function automatic ptb_msg_t mk(input logic [7:0] b0, input logic [7:0] bj);
        ptb_msg_t m;
        m = '0;
        m[0] = b0;
        for (int j = 1; j < PTB_LEN_SHORT; j++) m[j] = bj + 8'(j);
        return m;
    endfunction : mk

    task automatic send(input ptb_msg_t m, input int n);
        repeat (n) i_ptb_poh_model.put_msg(m, PTB_LEN_SHORT);
    endtask : send

    // main sequence
    initial begin
        rst_n = 1'b0;
        addr = 10'h000;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h00000000;
        be = 4'hF;
        n_mismatch = 0;
        tests_run = 0;
        cycles = 0;
        m_a = mk(8'hA5, 8'h30);
        m_b = mk(8'hB1, 8'h50);
        m_c = mk(8'hB2, 8'h60);
        do_reset();
        // reset values and an unmapped place
        rd_chk(PTB_IDX_CTRL, PTB_CTRL_RESET);
        rd_chk(PTB_IDX_STAT, 8'h00);
        rd_chk(PTB_IDX_IADDR, 8'h00);
        rd_chk(PTB_IDX_IDATA, 8'h00);
        irq_chk(1'b1);
        wr_reg(8'h6C, 8'h5A);
        rd_chk(8'h6C, 8'h00);
        // write with the low byte lane off is dropped
        be <= 4'hE;
        wr_reg(PTB_IDX_CTRL, 8'h5A);
        be <= 4'hF;
        rd_chk(PTB_IDX_CTRL, PTB_CTRL_RESET);
        // transmit buffer edited under zero message, first 16 bytes only
        wr_reg(PTB_IDX_CTRL, 8'h05);
        for (int j = 0; j < 16; j++) ind_write(7'(j), 8'(8'h40 + j));
        ind_chk(7'h03, 8'h43);
        wr_reg(PTB_IDX_CTRL, 8'h01);
        for (int j = 0; j < 17; j++) begin
            i_ptb_poh_model.get_byte(q8);
            chk(q8, 8'(8'h40 + (j % PTB_LEN_SHORT)));
        end
        wr_reg(PTB_IDX_CTRL, 8'h05);
        i_ptb_poh_model.get_byte(q8);
        chk(q8, PTB_BYTE_ZERO);
        // expected page on the receive side
        wr_reg(PTB_IDX_CTRL, 8'h41);
        ind_chk(7'h03, 8'h00);
        for (int j = 0; j < 16; j++) ind_write(7'(64 + j), m_a[j]);
        ind_chk(7'h45, m_a[5]);
        rd_chk(PTB_IDX_STAT, 8'h01);
        // three-fold persistence after stray bytes
        wr_reg(PTB_IDX_CTRL, 8'h51);
        for (int j = 1; j < 4; j++) i_ptb_poh_model.put_byte(8'(j));
        send(m_a, 2);
        rd_chk(PTB_IDX_STAT, 8'h01);
        irq_chk(1'b1);
        send(m_a, 1);
        irq_chk(1'b0);
        rd_chk(PTB_IDX_STAT, 8'h02);
        irq_chk(1'b1);
        rd_chk(PTB_IDX_STAT, 8'h00);
        // five-fold persistence, restarted by one odd message
        wr_reg(PTB_IDX_CTRL, 8'h49);
        send(m_b, 4);
        send(m_c, 1);
        send(m_b, 4);
        rd_chk(PTB_IDX_STAT, 8'h00);
        send(m_b, 1);
        irq_chk(1'b1);
        rd_chk(PTB_IDX_STAT, 8'h03);
        // eight differing messages make it unstable
        wr_reg(PTB_IDX_CTRL, 8'h61);
        for (int k = 1; k < 8; k++) send(mk(8'(8'hC0 + k), 8'(8'h08 + k)), 1);
        rd_chk(PTB_IDX_STAT, 8'h01);
        irq_chk(1'b1);
        send(mk(8'hC8, 8'h10), 1);
        irq_chk(1'b0);
        rd_chk(PTB_IDX_STAT, 8'h0D);
        rd_chk(PTB_IDX_STAT, 8'h05);
        send(m_a, 3);
        rd_chk(PTB_IDX_STAT, 8'h0A);
        for (int j = 0; j < 16; j++) ind_chk(7'(j), m_a[j]);
        // long message: byte after cr lf goes first
        wr_reg(PTB_IDX_CTRL, 8'h40);
        i_ptb_poh_model.put_byte(8'h21);
        i_ptb_poh_model.put_byte(PTB_CR);
        i_ptb_poh_model.put_byte(PTB_LF);
        i_ptb_poh_model.put_byte(8'h55);
        i_ptb_poh_model.put_byte(8'h66);
        i_ptb_poh_model.idle();
        ind_chk(7'h00, 8'h55);
        ind_chk(7'h01, 8'h66);
        // second reset, then plain circular capture
        do_reset();
        rd_chk(PTB_IDX_CTRL, PTB_CTRL_RESET);
        wr_reg(PTB_IDX_CTRL, 8'h43);
        i_ptb_poh_model.put_byte(8'h11);
        i_ptb_poh_model.put_byte(8'h92);
        i_ptb_poh_model.put_byte(8'h33);
        i_ptb_poh_model.idle();
        ind_chk(7'h00, 8'h11);
        ind_chk(7'h01, 8'h92);
        ind_chk(7'h02, 8'h33);
        wrap_up();
    end
endmodule : ptb_trace_buffer_tb
